// file: rtl/pcr_pkg.sv
// Function
// - bits 7..5 per external regulator: zero checks power-good input, one ignores it.
// - overvoltage select bits 7..2 for rails one to five and ldo; one means 120 percent.
// - overvoltage select zero makes the threshold follow the primary overvoltage setting.
// - undervoltage select bits 7..2 for rails and ldo; zero follows primary undervoltage setting.
// - nonvolatile byte holds lowest two lot characters, first in upper nibble.
`default_nettype none
package pcr_pkg;
	// -------------------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------------------
	localparam logic [7:0] PCR_ADDR_PG_IGNORE = 8'h7a;
	localparam logic [7:0] PCR_ADDR_OV_SEL    = 8'h7b;
	localparam logic [7:0] PCR_ADDR_UV_SEL    = 8'h7c;
	localparam logic [7:0] PCR_ADDR_LOT_CHARS = 8'hb1;
	// -------------------------------------------------------------------------
	// field layout
	// -------------------------------------------------------------------------
	localparam int PCR_NUM_EXT   = 3;   // external regulators
	localparam int PCR_NUM_RAIL  = 6;   // rails one to five and the ldo
	localparam int PCR_PG_MSB    = 7;   // ignore bits 7..5
	localparam int PCR_PG_LSB    = 5;
	localparam int PCR_SEL_MSB   = 7;   // select bits 7..2
	localparam int PCR_SEL_LSB   = 2;
	localparam int PCR_LOT1_MSB  = 7;   // first character nibble
	localparam int PCR_LOT1_LSB  = 4;
	localparam int PCR_LOT2_MSB  = 3;   // second character nibble
	localparam int PCR_LOT2_LSB  = 0;
	// -------------------------------------------------------------------------
	// reset values and threshold codes
	// -------------------------------------------------------------------------
	localparam logic [7:0] PCR_RST_BYTE    = 8'h00;
	localparam int         PCR_OV_HIGH_PCT = 120; // level meant by the high overvoltage code
	localparam int         PCR_THR_W       = 4;   // width of a threshold code
	localparam logic [3:0] PCR_OV_HIGH     = 4'hf; // code for the 120 percent level
	localparam logic [3:0] PCR_UV_LOW      = 4'h0; // code for the lower undervoltage level
endpackage : pcr_pkg
`default_nettype wire

// file: rtl/pcr_thresh_sel.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_thresh_sel #(
	parameter int NUM_RAIL = 6,
	parameter int THR_W    = 4
) (
	input  wire logic [NUM_RAIL-1:0]       ov_high_sel_in,
	input  wire logic [NUM_RAIL-1:0]       uv_low_sel_in,
	input  wire logic [NUM_RAIL*THR_W-1:0] primary_overvoltage_config_in,
	input  wire logic [NUM_RAIL*THR_W-1:0] primary_undervoltage_config_in,
	output logic      [NUM_RAIL*THR_W-1:0] ov_thresh_out,
	output logic      [NUM_RAIL*THR_W-1:0] uv_thresh_out
);
	// -------------------------------------------------------------------------
	// per-rail threshold choice
	// -------------------------------------------------------------------------
	for (genvar i = 0; i < NUM_RAIL; i++) begin : g_rail
		// high select picks the fixed code, otherwise the primary setting
		assign ov_thresh_out[i*THR_W +: THR_W] = ov_high_sel_in[i] ?
			THR_W'(pcr_pkg::PCR_OV_HIGH) :
			primary_overvoltage_config_in[i*THR_W +: THR_W];
		assign uv_thresh_out[i*THR_W +: THR_W] = uv_low_sel_in[i] ?
			THR_W'(pcr_pkg::PCR_UV_LOW) :
			primary_undervoltage_config_in[i*THR_W +: THR_W];
	end
endmodule : pcr_thresh_sel
`default_nettype wire

// file: rtl/pcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_regs #(
	parameter int NUM_EXT  = 3,
	parameter int NUM_RAIL = 6,
	parameter int THR_W    = 4
) (
	input  wire logic                      clk_in,
	input  wire logic                      rst_b_in,
	input  wire logic [7:0]                reg_addr_in,
	input  wire logic                      reg_wr_in,
	input  wire logic [7:0]                reg_wdata_in,
	input  wire logic                      reg_rd_in,
	output logic      [7:0]                reg_rdata_out,
	output logic                           reg_rvalid_out,
	input  wire logic                      nvm_load_in,
	input  wire logic [7:0]                nvm_data_in,
	input  wire logic [NUM_EXT-1:0]        ext_regulator_power_good_in,
	input  wire logic [NUM_RAIL*THR_W-1:0] primary_overvoltage_config_in,
	input  wire logic [NUM_RAIL*THR_W-1:0] primary_undervoltage_config_in,
	output logic      [NUM_RAIL*THR_W-1:0] ov_thresh_out,
	output logic      [NUM_RAIL*THR_W-1:0] uv_thresh_out,
	output logic      [NUM_EXT-1:0]        ext_pg_fault_out,
	output logic      [7:0]                lot_serial_chars_out
);
	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_EXT-1:0]        pg_ignore;
		logic [NUM_RAIL-1:0]       ov_sel;
		logic [NUM_RAIL-1:0]       uv_sel;
		logic [7:0]                lot;
		logic [7:0]                rdata;
		logic                      rvalid;
		logic [NUM_EXT-1:0]        pg_s1;
		logic [NUM_EXT-1:0]        pg_s2;
		logic [NUM_EXT-1:0]        pg_s3;
		logic [NUM_EXT-1:0]        pg_filt;
		logic [NUM_EXT-1:0]        pg_fault;
		logic [NUM_RAIL*THR_W-1:0] ov_thr;
		logic [NUM_RAIL*THR_W-1:0] uv_thr;
	} pcr_state_s;

	pcr_state_s                st;
	pcr_state_s                next_st;
	logic [NUM_RAIL*THR_W-1:0] sel_ov_thr;
	logic [NUM_RAIL*THR_W-1:0] sel_uv_thr;
	logic [NUM_RAIL-1:0]       ov_sel_rail;
	logic [NUM_RAIL-1:0]       uv_sel_rail;
	logic [NUM_EXT-1:0]        pg_ignore_by_pin;

	// -------------------------------------------------------------------------
	// bit order: rail one and regulator one sit in the top bit of their byte
	// -------------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_RAIL; i++) begin
			ov_sel_rail[i] = st.ov_sel[NUM_RAIL-1-i];
			uv_sel_rail[i] = st.uv_sel[NUM_RAIL-1-i];
		end
		// pin bit zero is regulator one, whose ignore bit is the top one
		for (int e = 0; e < NUM_EXT; e++) begin
			pg_ignore_by_pin[e] = st.pg_ignore[NUM_EXT-1-e];
		end
	end

	pcr_thresh_sel #(
		.NUM_RAIL (NUM_RAIL),
		.THR_W    (THR_W)
	) u_thresh_sel (
		.ov_high_sel_in                 (ov_sel_rail),
		.uv_low_sel_in                  (uv_sel_rail),
		.primary_overvoltage_config_in  (primary_overvoltage_config_in),
		.primary_undervoltage_config_in (primary_undervoltage_config_in),
		.ov_thresh_out                  (sel_ov_thr),
		.uv_thresh_out                  (sel_uv_thr)
	);

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb begin
		next_st = st;
		// power-good pins: three flops, a change counts once stages two and three agree
		next_st.pg_s1 = ext_regulator_power_good_in;
		next_st.pg_s2 = st.pg_s1;
		next_st.pg_s3 = st.pg_s2;
		for (int e = 0; e < NUM_EXT; e++) begin
			if (st.pg_s2[e] == st.pg_s3[e]) begin
				next_st.pg_filt[e] = st.pg_s3[e];
			end
		end
		// fault only for a monitored regulator whose power-good is low
		next_st.pg_fault = ~st.pg_filt & ~pg_ignore_by_pin;
		next_st.ov_thr   = sel_ov_thr;
		next_st.uv_thr   = sel_uv_thr;
		// nonvolatile load first, a host write in the same cycle wins
		if (nvm_load_in) begin
			next_st.lot = nvm_data_in;
		end
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				pcr_pkg::PCR_ADDR_PG_IGNORE: begin
					next_st.pg_ignore =
						reg_wdata_in[pcr_pkg::PCR_PG_MSB:pcr_pkg::PCR_PG_LSB];
				end
				pcr_pkg::PCR_ADDR_OV_SEL: begin
					next_st.ov_sel =
						reg_wdata_in[pcr_pkg::PCR_SEL_MSB:pcr_pkg::PCR_SEL_LSB];
				end
				pcr_pkg::PCR_ADDR_UV_SEL: begin
					next_st.uv_sel =
						reg_wdata_in[pcr_pkg::PCR_SEL_MSB:pcr_pkg::PCR_SEL_LSB];
				end
				pcr_pkg::PCR_ADDR_LOT_CHARS: begin
					next_st.lot = reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
		// read answer one cycle later; reserved bits and unmapped bytes read zero
		next_st.rvalid = reg_rd_in;
		if (reg_rd_in) begin
			next_st.rdata = pcr_pkg::PCR_RST_BYTE;
			unique case (reg_addr_in)
				pcr_pkg::PCR_ADDR_PG_IGNORE: begin
					next_st.rdata[pcr_pkg::PCR_PG_MSB:pcr_pkg::PCR_PG_LSB] = st.pg_ignore;
				end
				pcr_pkg::PCR_ADDR_OV_SEL: begin
					next_st.rdata[pcr_pkg::PCR_SEL_MSB:pcr_pkg::PCR_SEL_LSB] = st.ov_sel;
				end
				pcr_pkg::PCR_ADDR_UV_SEL: begin
					next_st.rdata[pcr_pkg::PCR_SEL_MSB:pcr_pkg::PCR_SEL_LSB] = st.uv_sel;
				end
				pcr_pkg::PCR_ADDR_LOT_CHARS: begin
					next_st.rdata = st.lot;
				end
				default: begin
				end
			endcase
		end
		// synchronous reset clears all but the pin filter: checking on, primary selects, threshold codes zero
		if (!rst_b_in) begin
			next_st = '0;
			// pin filter restarts at the good level, so no false fault follows reset
			next_st.pg_s1   = '1;
			next_st.pg_s2   = '1;
			next_st.pg_s3   = '1;
			next_st.pg_filt = '1;
		end
	end

	// -------------------------------------------------------------------------
	// state register
	// -------------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		st <= next_st;
	end

	// outputs straight from flops
	assign reg_rdata_out        = st.rdata;
	assign reg_rvalid_out       = st.rvalid;
	assign ov_thresh_out        = st.ov_thr;
	assign uv_thresh_out        = st.uv_thr;
	assign ext_pg_fault_out     = st.pg_fault;
	assign lot_serial_chars_out = st.lot;

	// -------------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------------
	a_pg_ignore_mask: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$past(rst_b_in) && $past(pg_ignore_by_pin[0]) |-> !ext_pg_fault_out[0])
		else $error("ignored regulator raised a power-good fault");

	a_pg_low_fault: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ext_regulator_power_good_in[1] == 1'b0) [*4] ##1 (st.pg_ignore[1] == 1'b0)
		|=> ext_pg_fault_out[1])
		else $error("monitored regulator low without fault");

	a_ov_high_code: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		reg_wr_in && reg_addr_in == pcr_pkg::PCR_ADDR_OV_SEL && reg_wdata_in[7]
		|=> ##1 ov_thresh_out[THR_W-1:0] == THR_W'(pcr_pkg::PCR_OV_HIGH))
		else $error("rail one not at high overvoltage code");

	a_ov_primary: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!st.ov_sel[pcr_pkg::PCR_SEL_LSB-2] && $stable(st.ov_sel)
		|=> ov_thresh_out[(NUM_RAIL-1)*THR_W +: THR_W] ==
			$past(primary_overvoltage_config_in[(NUM_RAIL-1)*THR_W +: THR_W]))
		else $error("ldo overvoltage threshold not from primary setting");

	a_uv_primary: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!st.uv_sel[NUM_RAIL-1]
		|=> uv_thresh_out[THR_W-1:0] == $past(primary_undervoltage_config_in[THR_W-1:0]))
		else $error("rail one undervoltage threshold not from primary setting");

	a_lot_readback: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		reg_rd_in && reg_addr_in == pcr_pkg::PCR_ADDR_LOT_CHARS
		|=> reg_rvalid_out && reg_rdata_out == $past(lot_serial_chars_out))
		else $error("lot byte read back wrong");

	a_reset_clear: assert property (@(posedge clk_in)
		!rst_b_in |=> reg_rdata_out == 8'h00 && !reg_rvalid_out
			&& ext_pg_fault_out == '0 && lot_serial_chars_out == 8'h00)
		else $error("state not cleared by reset");

	a_pg_reserved_field_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		reg_rd_in && reg_addr_in == pcr_pkg::PCR_ADDR_PG_IGNORE
		|=> reg_rdata_out[pcr_pkg::PCR_PG_LSB-1:0] == '0)
		else $error("reserved ignore bits read nonzero");

	a_uv_sel_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		reg_wr_in && reg_addr_in == pcr_pkg::PCR_ADDR_UV_SEL
		|=> st.uv_sel == $past(reg_wdata_in[pcr_pkg::PCR_SEL_MSB:pcr_pkg::PCR_SEL_LSB]))
		else $error("undervoltage select write not stored");

	a_uv_low_code: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		reg_wr_in && reg_addr_in == pcr_pkg::PCR_ADDR_UV_SEL && reg_wdata_in[pcr_pkg::PCR_SEL_LSB]
		|=> ##1 uv_thresh_out[(NUM_RAIL-1)*THR_W +: THR_W] == THR_W'(pcr_pkg::PCR_UV_LOW))
		else $error("ldo not at low undervoltage code");

	a_lot_nvm_load: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		nvm_load_in && !(reg_wr_in && reg_addr_in == pcr_pkg::PCR_ADDR_LOT_CHARS)
		|=> lot_serial_chars_out == $past(nvm_data_in))
		else $error("lot byte not loaded from store");
endmodule : pcr_regs
`default_nettype wire

// file: verif/pcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the byte strobe port: one request per call, released lines inverted
module pcr_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] reg_rdata_in,
	input  wire logic       reg_rvalid_in,
	output logic      [7:0] reg_addr_out,
	output logic            reg_wr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_rd_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_out = 1'b0;
	end
	// one write strobe held for exactly one sampling edge
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_wr_out <= 1'b1;
		reg_wdata_out <= d;
		@(posedge clk_in);
		reg_wr_out <= 1'b0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask : write_byte
	// read strobe, then a bounded wait for the answer pulse
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		d = 8'hxx;
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clk_in);
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~a;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			if (reg_rvalid_in === 1'b1) begin
				d = reg_rdata_in;
				break;
			end
		end
	endtask : read_byte
endmodule : pcr_host_model
`default_nettype wire

// file: verif/protection_config_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module protection_config_registers_test;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        nvm_load_in = 1'b0;
	logic [7:0]  nvm_data_in = 8'h00;
	logic [2:0]  pg = 3'h7;
	logic [23:0] pov = 24'h123456;
	logic [23:0] puv = 24'h9abcde;
	logic [7:0]  addr, wdata, rdata, lot;
	logic        wr, rd, rvalid;
	logic [23:0] ov, uv;
	logic [2:0]  fault;
	int          failures = 0;
	int          compares = 0;
	always #5 clk_in = ~clk_in;
	pcr_host_model pcr_host_model_inst (.clk_in(clk_in), .reg_rdata_in(rdata),
		.reg_rvalid_in(rvalid), .reg_addr_out(addr), .reg_wr_out(wr),
		.reg_wdata_out(wdata), .reg_rd_out(rd));
	pcr_regs pcr_regs_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .nvm_load_in(nvm_load_in), .nvm_data_in(nvm_data_in),
		.ext_regulator_power_good_in(pg), .primary_overvoltage_config_in(pov),
		.primary_undervoltage_config_in(puv), .ov_thresh_out(ov), .uv_thresh_out(uv),
		.ext_pg_fault_out(fault), .lot_serial_chars_out(lot));
	// ---------------------------------------------------------------------
	// compare helpers
	// ---------------------------------------------------------------------
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		pcr_host_model_inst.read_byte(a, d);
		chk("read data", {16'h0000, e}, {16'h0000, d});
	endtask : rd_chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : settle
	// ---------------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------------
	task automatic t_reset;
		rd_chk(8'h7a, 8'h00);
		rd_chk(8'h7b, 8'h00);
		rd_chk(8'h7c, 8'h00);
		rd_chk(8'hb1, 8'h00);
		rd_chk(8'h7d, 8'h00);
		chk("ov threshold", pov, ov);
		chk("uv threshold", puv, uv);
		chk("pg fault idle", 24'h0, {21'h0, fault});
		$display("test reset done");
	endtask : t_reset
	task automatic t_pg;
		pcr_host_model_inst.write_byte(8'h7a, 8'hff);
		rd_chk(8'h7a, 8'he0);
		pcr_host_model_inst.write_byte(8'h7a, 8'h40);
		@(posedge clk_in) pg <= 3'h6;
		settle(8);
		chk("pg fault monitored", 24'h1, {21'h0, fault});
		pcr_host_model_inst.write_byte(8'h7a, 8'h80);
		settle(2);
		chk("pg fault ignored", 24'h0, {21'h0, fault});
		@(posedge clk_in) pg <= 3'h5;
		settle(8);
		chk("pg fault reg2", 24'h2, {21'h0, fault});
		@(posedge clk_in) pg <= 3'h7;
		$display("test power good done");
	endtask : t_pg
	task automatic t_ov;
		pcr_host_model_inst.write_byte(8'h7b, 8'hff);
		rd_chk(8'h7b, 8'hfc);
		pcr_host_model_inst.write_byte(8'h7b, 8'h80);
		settle(2);
		chk("ov rail1 high", 24'h12345f, ov);
		@(posedge clk_in) pov <= 24'h654321;
		settle(2);
		chk("ov follows primary", 24'h65432f, ov);
		$display("test overvoltage done");
	endtask : t_ov
	task automatic t_uv;
		pcr_host_model_inst.write_byte(8'h7c, 8'h04);
		rd_chk(8'h7c, 8'h04);
		settle(2);
		chk("uv ldo low", 24'h0abcde, uv);
		$display("test undervoltage done");
	endtask : t_uv
	task automatic t_lot;
		@(posedge clk_in);
		nvm_load_in <= 1'b1;
		nvm_data_in <= 8'h71;
		@(posedge clk_in) nvm_load_in <= 1'b0;
		rd_chk(8'hb1, 8'h71);
		chk("lot chars", 24'h71, {16'h0000, lot});
		pcr_host_model_inst.write_byte(8'hb1, 8'h5a);
		rd_chk(8'hb1, 8'h5a);
		$display("test lot done");
	endtask : t_lot
	task automatic t_rerst;
		@(posedge clk_in) rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		settle(2);
		chk("fault after reset", 24'h0, {21'h0, fault});
		chk("lot after reset", 24'h0, {16'h0000, lot});
		chk("ov after reset", pov, ov);
		rd_chk(8'h7b, 8'h00);
		rd_chk(8'h7a, 8'h00);
		$display("test mid reset done");
	endtask : t_rerst
	// ---------------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ---------------------------------------------------------------------
	task automatic report_and_stop;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		#50000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		settle(2);
		t_reset();
		t_pg();
		t_ov();
		t_uv();
		t_lot();
		t_rerst();
		report_and_stop();
	end
endmodule : protection_config_registers_test
`default_nettype wire
